// ---- hdl/urx_receive_path.sv ----
// UART receive path: baud generator, glitch filter, deserialiser, FIFO.
// Assumes the serial line is asynchronous and the reader is on CLK_I.
`timescale 1ns/1ns
module urx_receive_path #(
   parameter int unsigned DEPTH = urx_pkg::FIFO_DEPTH
) (
   input  wire logic        CLK_I,
   input  wire logic        RST_N_I,
   input  wire logic        RXD_I,
   input  wire logic [15:0] DIVISOR_I,
   input  wire logic [1:0]  WORD_LEN_I,
   input  wire logic [1:0]  STOP_SEL_I,
   input  wire logic        PAR_EN_I,
   input  wire logic        PAR_EVEN_I,
   input  wire logic        PAR_STICK_I,
   input  wire logic        FIFO_EN_I,
   input  wire logic [1:0]  TRIG_SEL_I,
   input  wire logic        FIFO_RST_I,
   input  wire logic        RDA_IE_I,
   input  wire logic        LSR_IE_I,
   input  wire logic        RD_I,
   input  wire logic        ERR_CLR_I,
   output logic      [7:0]  DATA_O,
   output logic             DATA_RDY_O,
   output logic             OVERRUN_O,
   output logic             PAR_ERR_O,
   output logic             FRM_ERR_O,
   output logic             TIMEOUT_O,
   output logic      [4:0]  FILL_O,
   output logic             RDA_IRQ_O,
   output logic             LSR_IRQ_O
);
   // Pointers and the fill count are sized for sixteen entries only
   if (DEPTH != 16) begin
      $error("DEPTH must be 16");
   end

   // ****************************************************************
   // Line synchroniser and baud generator
   // ****************************************************************
   logic        rx_s1_r, rx_s2_r;
   logic [15:0] div_cnt_r;
   logic        rclk_en;
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         rx_s1_r <= 1'b1;
         rx_s2_r <= 1'b1;
      end else begin
         rx_s1_r <= RXD_I;
         rx_s2_r <= rx_s1_r;
      end
   end
   // Divisor 0 is treated as 1 so the receive clock never stops
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I)
         div_cnt_r <= urx_pkg::DIV_RST;
      else if (div_cnt_r <= 16'h0001)
         div_cnt_r <= DIVISOR_I;
      else
         div_cnt_r <= div_cnt_r - 16'h0001;
   end
   assign rclk_en = (div_cnt_r <= 16'h0001);

   // ****************************************************************
   // Glitch filter
   // ****************************************************************
   // A new level must be seen on three receive clocks in a row, so no pulse under three passes
   logic       rx_f_r;
   logic [1:0] flt_cnt_r;
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         rx_f_r    <= 1'b1;
         flt_cnt_r <= 2'h0;
      end else if (rclk_en) begin
         if (rx_s2_r == rx_f_r)
            flt_cnt_r <= 2'h0;
         else if (flt_cnt_r == 2'(urx_pkg::FILT_LEN)) begin
            rx_f_r    <= rx_s2_r;
            flt_cnt_r <= 2'h0;
         end else
            flt_cnt_r <= flt_cnt_r + 2'h1;
      end
   end

   // ****************************************************************
   // Deserialiser
   // ****************************************************************
   urx_pkg::urx_state_e st_r;
   logic [3:0] ovs_r;
   logic [2:0] bit_r;
   logic [7:0] shf_r;
   logic       par_r;
   logic       stop2_r;
   logic       done_r;
   logic       pe_nxt, fe_nxt;
   logic [7:0] char_r;
   logic       pe_r, fe_r;
   logic       bit_tick;
   logic       par_exp;
   logic [2:0] last_bit;
   assign bit_tick = rclk_en && (ovs_r == 4'(urx_pkg::OVS_RATE - 1));
   assign last_bit = 3'(WORD_LEN_I) + 3'h4;
   // Expected parity over received bits, sticky forces a constant
   always_comb begin
      if (PAR_STICK_I)
         par_exp = ~PAR_EVEN_I;
      else
         par_exp = par_r ^ ~PAR_EVEN_I;
   end
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         st_r    <= urx_pkg::URX_IDLE;
         ovs_r   <= 4'h0;
         bit_r   <= 3'h0;
         shf_r   <= urx_pkg::DATA_RST;
         par_r   <= 1'b0;
         stop2_r <= 1'b0;
         done_r  <= 1'b0;
         char_r  <= urx_pkg::DATA_RST;
         pe_r    <= 1'b0;
         fe_r    <= 1'b0;
      end else begin
         done_r <= 1'b0;
         if (rclk_en) begin
            case (st_r)
               urx_pkg::URX_IDLE: begin
                  ovs_r <= 4'h0;
                  if (!rx_f_r)
                     st_r <= urx_pkg::URX_START;
               end
               urx_pkg::URX_START: begin
                  ovs_r <= ovs_r + 4'h1;
                  if (ovs_r == 4'(urx_pkg::OVS_MID - 1)) begin
                     ovs_r <= 4'h0;
                     bit_r <= 3'h0;
                     par_r <= 1'b0;
                     shf_r <= 8'h00;
                     pe_r  <= 1'b0;
                     fe_r  <= 1'b0;
                     st_r  <= rx_f_r ? urx_pkg::URX_IDLE : urx_pkg::URX_DATA;
                  end
               end
               urx_pkg::URX_DATA: begin
                  ovs_r <= ovs_r + 4'h1;
                  if (bit_tick) begin
                     shf_r[bit_r] <= rx_f_r;
                     par_r        <= par_r ^ rx_f_r;
                     bit_r        <= bit_r + 3'h1;
                     if (bit_r == last_bit)
                        st_r <= PAR_EN_I ? urx_pkg::URX_PARITY : urx_pkg::URX_STOP;
                  end
               end
               urx_pkg::URX_PARITY: begin
                  ovs_r <= ovs_r + 4'h1;
                  if (bit_tick) begin
                     pe_r <= (rx_f_r != par_exp);
                     st_r <= urx_pkg::URX_STOP;
                  end
               end
               urx_pkg::URX_STOP: begin
                  ovs_r <= ovs_r + 4'h1;
                  if (bit_tick) begin
                     if (!rx_f_r)
                        fe_r <= 1'b1;
                     // A second stop bit is checked only for two-stop framing
                     if (STOP_SEL_I != 2'h0 && WORD_LEN_I != urx_pkg::WLEN_5
                         && !stop2_r && rx_f_r)
                        stop2_r <= 1'b1;
                     else begin
                        stop2_r <= 1'b0;
                        char_r  <= shf_r;
                        done_r  <= 1'b1;
                        st_r    <= urx_pkg::URX_IDLE;
                     end
                  end
               end
               default: st_r <= urx_pkg::URX_IDLE;
            endcase
         end
      end
   end
   // Per-frame error bits are cleared at start confirm and reported with done
   assign pe_nxt = pe_r && done_r;
   assign fe_nxt = fe_r && done_r;

   // ****************************************************************
   // Holding register / FIFO
   // ****************************************************************
   logic [7:0] mem_r [DEPTH];
   logic [3:0] wp_r, rp_r;
   logic [4:0] cnt_r;
   logic       wr, rd, full, fen_r, fifo_clr;
   assign full = FIFO_EN_I ? (cnt_r == 5'(DEPTH)) : (cnt_r != 5'h0);
   assign wr   = done_r && !full;
   assign rd   = RD_I && (cnt_r != 5'h0);
   // A change of mode empties the store, so the holding register never keeps a deep fill
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I)
         fen_r <= 1'b0;
      else
         fen_r <= FIFO_EN_I;
   end
   assign fifo_clr = FIFO_RST_I || (FIFO_EN_I != fen_r);
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I || fifo_clr) begin
         wp_r  <= 4'h0;
         rp_r  <= 4'h0;
         cnt_r <= 5'h0;
      end else begin
         if (wr) begin
            mem_r[wp_r] <= char_r;
            wp_r        <= wp_r + 4'h1;
         end
         if (rd)
            rp_r <= rp_r + 4'h1;
         cnt_r <= cnt_r + 5'(wr) - 5'(rd);
      end
   end
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I)
         DATA_O <= urx_pkg::DATA_RST;
      else
         DATA_O <= (cnt_r != 5'h0) ? mem_r[rp_r] : urx_pkg::DATA_RST;
   end
   assign DATA_RDY_O = (cnt_r != 5'h0);
   assign FILL_O     = cnt_r;

   // ****************************************************************
   // Line status: set wins over clear
   // ****************************************************************
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         OVERRUN_O <= 1'b0;
         PAR_ERR_O <= 1'b0;
         FRM_ERR_O <= 1'b0;
      end else begin
         OVERRUN_O <= (done_r && full) || (OVERRUN_O && !ERR_CLR_I);
         PAR_ERR_O <= pe_nxt || (PAR_ERR_O && !ERR_CLR_I);
         FRM_ERR_O <= fe_nxt || (FRM_ERR_O && !ERR_CLR_I);
      end
   end

   // ****************************************************************
   // Trigger level and character timeout
   // ****************************************************************
   logic [4:0]  trig_lvl;
   logic [26:0] tmo_cnt_r;
   logic [26:0] tmo_lim;
   always_comb begin
      case (TRIG_SEL_I)
         urx_pkg::TRIG_1:  trig_lvl = urx_pkg::TRIG_LVL_1;
         urx_pkg::TRIG_4:  trig_lvl = urx_pkg::TRIG_LVL_4;
         urx_pkg::TRIG_8:  trig_lvl = urx_pkg::TRIG_LVL_8;
         default:          trig_lvl = urx_pkg::TRIG_LVL_14;
      endcase
   end
   // Four characters of twelve bit times, counted in receive clocks
   assign tmo_lim = 27'(urx_pkg::TMO_CHARS * 12 * urx_pkg::OVS_RATE);
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I || !FIFO_EN_I || cnt_r == 5'h0 || done_r || RD_I) begin
         tmo_cnt_r <= 27'h0;
         TIMEOUT_O <= 1'b0;
      end else if (rclk_en) begin
         if (tmo_cnt_r == tmo_lim - 27'h1)
            TIMEOUT_O <= 1'b1;
         else
            tmo_cnt_r <= tmo_cnt_r + 27'h1;
      end
   end
   assign RDA_IRQ_O = RDA_IE_I && (FIFO_EN_I ? (cnt_r >= trig_lvl || TIMEOUT_O)
                                             : (cnt_r != 5'h0));
   assign LSR_IRQ_O = LSR_IE_I && (OVERRUN_O || PAR_ERR_O || FRM_ERR_O);

   // ****************************************************************
   // Assertions
   // ****************************************************************
   sequence s_char_done;
      done_r && !full;
   endsequence
   AST_STORE: assert property (@(posedge CLK_I) disable iff (!RST_N_I || fifo_clr)
      (s_char_done and !rd) |=> cnt_r == $past(cnt_r) + 5'h1)
      else $error("character not stored");
   AST_NFIFO_ONE: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      !FIFO_EN_I && $past(!FIFO_EN_I) |-> cnt_r <= 5'h1)
      else $error("holding register exceeded one");
   AST_FIFO_CAP: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      cnt_r <= 5'(DEPTH))
      else $error("fifo overfilled");
   AST_TRIG: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      RDA_IE_I && FIFO_EN_I && cnt_r >= trig_lvl |-> RDA_IRQ_O)
      else $error("trigger interrupt missing");
   AST_PE_IRQ: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      LSR_IE_I && PAR_ERR_O |-> LSR_IRQ_O)
      else $error("parity interrupt missing");
   AST_FE_SET: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      st_r == urx_pkg::URX_STOP && bit_tick && !rx_f_r |=> ##1 FRM_ERR_O)
      else $error("framing error lost");
   AST_START_CONF: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      st_r == urx_pkg::URX_START && rclk_en && ovs_r == 4'h7 && rx_f_r
      |=> st_r == urx_pkg::URX_IDLE)
      else $error("false start accepted");
   AST_BAUD: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      rclk_en && DIVISOR_I > 16'h1 && $stable(DIVISOR_I) |=> !rclk_en)
      else $error("baud enable too frequent");
   // Separate tally of equal line samples, so the filter is judged by other logic
   logic       smp_prev_r;
   logic [1:0] smp_run_r;
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         smp_prev_r <= 1'b1;
         smp_run_r  <= 2'h0;
      end else if (rclk_en) begin
         smp_prev_r <= rx_s2_r;
         smp_run_r  <= (rx_s2_r != smp_prev_r) ? 2'h0 : smp_run_r + {1'b0, smp_run_r != 2'h3};
      end
   end
   AST_FILTER: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      $changed(rx_f_r) |-> rx_f_r == smp_prev_r && smp_run_r >= 2'h2)
      else $error("filter passed glitch");
endmodule

// ---- hdl/urx_pkg.sv ----
// Constants shared by the UART receive path.
// Assumes a single 100 MHz system clock and a synchronous active-low reset.
package urx_pkg;
   // ****************************************************************
   // Oversampling and framing
   // ****************************************************************
   localparam int unsigned OVS_RATE      = 16;   // Receive clocks per bit
   localparam int unsigned OVS_MID       = 8;    // Start bit confirm point
   localparam int unsigned FILT_LEN      = 2;    // Glitch reject length
   localparam int unsigned FIFO_DEPTH    = 16;
   localparam int unsigned TMO_CHARS     = 4;    // Character times to timeout
   localparam logic [15:0] DIV_RST       = 16'h0001;
   localparam logic [7:0]  DATA_RST      = 8'h00;
   // ****************************************************************
   // Field encodings
   // ****************************************************************
   localparam logic [1:0]  WLEN_5        = 2'h0;
   localparam logic [1:0]  WLEN_8        = 2'h3;
   localparam logic [1:0]  TRIG_1        = 2'h0;
   localparam logic [1:0]  TRIG_4        = 2'h1;
   localparam logic [1:0]  TRIG_8        = 2'h2;
   localparam logic [1:0]  TRIG_14       = 2'h3;
   localparam logic [4:0]  TRIG_LVL_1    = 5'h01;
   localparam logic [4:0]  TRIG_LVL_4    = 5'h04;
   localparam logic [4:0]  TRIG_LVL_8    = 5'h08;
   localparam logic [4:0]  TRIG_LVL_14   = 5'h0e;
   typedef enum logic [2:0] {
      URX_IDLE   = 3'b000,
      URX_START  = 3'b001,
      URX_DATA   = 3'b010,
      URX_PARITY = 3'b011,
      URX_STOP   = 3'b100
   } urx_state_e;
endpackage

// ---- testbench/urx_tx_model.sv ----
// Serial transmitter model that drives the receive line of the path.
// Assumes the bench calls its tasks from one process, just after a clock edge.
`timescale 1ns/1ns
module urx_tx_model (
   input  wire logic clk_i,
   output logic      line_o
);
   initial line_o = 1'b1;

   // Holds one line level for a number of clock cycles
   task automatic hold(input logic v, input int n);
      line_o = v;
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   // par is {sticky, even, enable}; hstop counts half bits, so 3 gives one and a half
   task automatic send(input logic [7:0] d, input int nb, input logic [2:0] par,
                       input int hstop, input int bc, input logic bad_par, bad_stop);
      logic p;
      @(posedge clk_i);
      #1;
      p = (^(d & (8'hff >> (8 - nb)))) ^ ~par[1];
      hold(1'b0, bc);
      for (int i = 0; i < nb; i++) begin
         hold(d[i], bc);
      end
      if (par[0]) begin
         hold((par[2] ? ~par[1] : p) ^ bad_par, bc);
      end
      // Only the first stop bit is spoiled, so a bad stop never looks like a new start
      hold(~bad_stop, bc);
      if (hstop > 2)
         hold(1'b1, bc * (hstop - 2) / 2);
      hold(1'b1, bc);
   endtask

   // A short low pulse followed by a long idle stretch
   task automatic glitch(input int n);
      @(posedge clk_i);
      #1;
      hold(1'b0, n);
      hold(1'b1, 60);
   endtask
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the receive path.
// Assumes the path treats a divisor of 1 as sixteen clocks per bit.
`timescale 1ns/1ns
module testbench;
   logic        clk = 1'b0, rst_n = 1'b0, line, pen = 1'b0, pev = 1'b0, pst = 1'b0;
   logic        fen = 1'b0, frst = 1'b0, rda_ie = 1'b1, lsr_ie = 1'b1, rd = 1'b0, eclr = 1'b0;
   logic [15:0] div = 16'h0001;
   logic [1:0]  wlen = 2'h3, stop_sel = 2'h0, trig = 2'h0;
   logic [7:0]  dout;
   logic [4:0]  fill;
   logic        rdy, ovr, perr, ferr, tmo, rda_irq, lsr_irq;
   int          errors = 0, check_count = 0;
   always #5 clk = ~clk;
   urx_tx_model tx (.clk_i(clk), .line_o(line));
   urx_receive_path dut (.CLK_I(clk), .RST_N_I(rst_n), .RXD_I(line), .DIVISOR_I(div),
      .WORD_LEN_I(wlen), .STOP_SEL_I(stop_sel), .PAR_EN_I(pen), .PAR_EVEN_I(pev),
      .PAR_STICK_I(pst), .FIFO_EN_I(fen), .TRIG_SEL_I(trig), .FIFO_RST_I(frst),
      .RDA_IE_I(rda_ie), .LSR_IE_I(lsr_ie), .RD_I(rd), .ERR_CLR_I(eclr), .DATA_O(dout),
      .DATA_RDY_O(rdy), .OVERRUN_O(ovr), .PAR_ERR_O(perr), .FRM_ERR_O(ferr),
      .TIMEOUT_O(tmo), .FILL_O(fill), .RDA_IRQ_O(rda_irq), .LSR_IRQ_O(lsr_irq));
   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic chk(input string nm, input logic [15:0] got, exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic rd_one();
      rd = 1'b1;
      step(1);
      rd = 1'b0;
      step(1);
   endtask
   task automatic pulse_clr();
      eclr = 1'b1;
      frst = fen;
      step(1);
      eclr = 1'b0;
      frst = 1'b0;
      step(1);
   endtask
   task automatic frame(input logic [7:0] d, input logic bp, bs);
      tx.send(d, 32'(wlen) + 5, {pst, pev, pen},
              stop_sel == 2'h0 ? 2 : (wlen == 2'h0 ? 3 : 4), 16 * int'(div), bp, bs);
      step(4);
   endtask
   task automatic test_done();
      $display("Checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_basic();
      chk("irq idle", 16'(rda_irq), 16'h0);
      frame(8'ha5, 1'b0, 1'b0);
      chk("ready", 16'(rdy), 16'h1);
      chk("data", 16'(dout), 16'h00a5);
      chk("rda irq", 16'(rda_irq), 16'h1);
      rda_ie = 1'b0;
      step(1);
      chk("rda masked", 16'(rda_irq), 16'h0);
      rda_ie = 1'b1;
      frame(8'h3c, 1'b0, 1'b0);
      chk("overrun", 16'(ovr), 16'h1);
      chk("kept data", 16'(dout), 16'h00a5);
      rd_one();
      chk("empty", 16'(rdy), 16'h0);
      pulse_clr();
      chk("overrun clr", 16'(ovr), 16'h0);
   endtask
   task automatic t_formats();
      logic [2:0] pm[5] = '{3'b000, 3'b001, 3'b011, 3'b101, 3'b111};
      logic [7:0] d;
      for (int w = 0; w < 4; w++) begin
         for (int m = 0; m < 5; m++) begin
            wlen = 2'(w);
            stop_sel = 2'((w + m) % 2);
            {pst, pev, pen} = pm[m];
            d = 8'h96 ^ 8'(w * 5 + m);
            frame(d, 1'b0, 1'b0);
            chk("fmt data", 16'(dout), 16'(d & (8'hff >> (3 - w))));
            chk("fmt perr", 16'(perr), 16'h0);
            chk("fmt ferr", 16'(ferr), 16'h0);
            rd_one();
         end
      end
      frame(8'h41, 1'b1, 1'b0);
      chk("bad parity", 16'(perr), 16'h1);
      chk("lsr irq", 16'(lsr_irq), 16'h1);
      rd_one();
      pulse_clr();
      frame(8'h42, 1'b0, 1'b1);
      chk("bad stop", 16'(ferr), 16'h1);
      lsr_ie = 1'b0;
      step(1);
      chk("lsr masked", 16'(lsr_irq), 16'h0);
      lsr_ie = 1'b1;
      rd_one();
      pulse_clr();
   endtask
   task automatic t_glitch();
      tx.glitch(1);
      chk("glitch", 16'(fill), 16'h0);
      tx.glitch(4);
      chk("false start", 16'(rdy), 16'h0);
      div = 16'h0004;
      tx.glitch(7);
      chk("slow glitch", 16'(rdy), 16'h0);
      frame(8'h5a, 1'b0, 1'b0);
      chk("div data", 16'(dout), 16'h005a);
      rd_one();
      div = 16'h0001;
   endtask
   task automatic t_fifo();
      int lv[4] = '{1, 4, 8, 14};
      fen = 1'b1;
      for (int t = 0; t < 4; t++) begin
         trig = 2'(t);
         pulse_clr();
         for (int i = 1; i < lv[t]; i++)
            frame(8'(i), 1'b0, 1'b0);
         chk("below trig", 16'(rda_irq), 16'h0);
         frame(8'hee, 1'b0, 1'b0);
         chk("at trig", 16'(rda_irq), 16'h1);
         chk("fill", 16'(fill), 16'(lv[t]));
      end
      pulse_clr();
      for (int i = 0; i < 17; i++)
         frame(8'(i * 7 + 1), 1'b0, 1'b0);
      chk("full", 16'(fill), 16'h0010);
      chk("fifo ovr", 16'(ovr), 16'h1);
      for (int i = 0; i < 16; i++) begin
         chk("fifo data", 16'(dout), 16'(8'(i * 7 + 1)));
         rd_one();
      end
      chk("drained", 16'(rdy), 16'h0);
      pulse_clr();
   endtask
   task automatic t_timeout();
      int n = 0;
      trig = 2'h1;
      frame(8'h77, 1'b0, 1'b0);
      step(730);
      chk("no tmo yet", 16'(tmo), 16'h0);
      while (tmo !== 1'b1 && n < 40) begin
         step(1);
         n++;
      end
      chk("tmo", 16'(tmo), 16'h1);
      chk("tmo irq", 16'(rda_irq), 16'h1);
      rd_one();
      chk("tmo clr", 16'(tmo), 16'h0);
   endtask
   initial begin
      step(3);
      rst_n = 1'b1;
      step(2);
      t_basic();
      t_formats();
      t_glitch();
      t_fifo();
      t_timeout();
      test_done();
   end
   initial begin
      repeat (60000) @(posedge clk);
      errors++;
      test_done();
   end
endmodule
